// ### src/dhm_mailbox_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dhm_mailbox_mem import dhm_pkg::*; (
   input wire logic core_clk,
   dhm_mbx_if.mem mbx
);
   logic [7:0] host_byte_reg [0:7]; // Host to core bytes
   logic [15:0] dsp_word_reg [0:3]; // Core to host words
   logic [15:0] host_word;

   // Host fills bank B 00-07 only
   always_ff @(posedge core_clk) begin
      if (mbx.host_we) begin
         host_byte_reg[mbx.host_waddr] <= mbx.host_wdata;
      end
   end

   // Core word store, separate from host bytes
   always_ff @(posedge core_clk) begin
      if (mbx.dsp_we) begin
         dsp_word_reg[mbx.dsp_idx] <= mbx.dsp_wdata;
      end
   end

   // Even byte high, odd byte low
   assign host_word = {host_byte_reg[{mbx.dsp_idx, 1'b0}],
      host_byte_reg[{mbx.dsp_idx, 1'b1}]};

   // Registered read ports
   always_ff @(posedge core_clk) begin
      mbx.dsp_rdata <= host_word;
      if (!mbx.host_raddr[3]) begin
         mbx.host_rdata <= host_byte_reg[mbx.host_raddr[2:0]];
      end else if (!mbx.host_raddr[0]) begin
         mbx.host_rdata <= dsp_word_reg[mbx.host_raddr[2:1]][15:8];
      end else begin
         mbx.host_rdata <= dsp_word_reg[mbx.host_raddr[2:1]][7:0];
      end
   end
endmodule // dhm_mailbox_mem
`default_nettype wire

// ### src/dhm_mbx_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dhm_mbx_if;
   logic host_we; // Host byte write, bank B 00-07
   logic [2:0] host_waddr; // Host byte position
   logic [7:0] host_wdata; // Host byte data
   logic [3:0] host_raddr; // Host read position 00-0F
   logic [7:0] host_rdata; // Registered host read byte
   logic dsp_we; // Core word write
   logic [1:0] dsp_idx; // Core word index
   logic [15:0] dsp_wdata; // Core word data
   logic [15:0] dsp_rdata; // Registered host-written word
   modport ctl (output host_we, host_waddr, host_wdata, host_raddr,
      dsp_we, dsp_idx, dsp_wdata, input host_rdata, dsp_rdata);
   modport mem (input host_we, host_waddr, host_wdata, host_raddr,
      dsp_we, dsp_idx, dsp_wdata, output host_rdata, dsp_rdata);
endinterface
`default_nettype wire

// ### src/dhm_pkg.sv
package dhm_pkg;
   // Extended register indices on the core side
   localparam logic [2:0] IDX_MBX0 = 3'h0;
   localparam logic [2:0] IDX_MBX3 = 3'h3;
   localparam logic [2:0] IDX_ICW = 3'h4;
   localparam logic [2:0] IDX_CDW = 3'h5;
   localparam logic [2:0] IDX_ACW = 3'h6;
   // Interrupt control word fields
   localparam int ICW_REQ_HI = 15;
   localparam int ICW_REQ_LO = 13;
   localparam int ICW_MASK_HI = 12;
   localparam int ICW_MASK_LO = 10;
   localparam int ICW_D2H = 9;
   localparam int ICW_GIE = 8;
   localparam int ICW_PRIO_HI = 7;
   localparam int ICW_PRIO_LO = 5;
   localparam int ICW_CLR_HI = 4;
   localparam int ICW_CLR_LO = 2;
   // Analog control word fields
   localparam int ACW_DRATE_HI = 15;
   localparam int ACW_DRATE_LO = 14;
   localparam int ACW_PIN_B = 7;
   localparam int ACW_PIN_A = 6;
   localparam int ACW_ADC_EN = 5;
   localparam int ACW_DONE = 4;
   localparam int ACW_START = 3;
   localparam int ACW_ARATE_HI = 1;
   localparam int ACW_ARATE_LO = 0;
   localparam logic [15:0] ACW_RST = 16'h0008;
   localparam logic [15:0] ACW_WMASK = 16'hC0EB;
   // Converter data word fields
   localparam int DAC_W = 10;
   localparam int ADC_LSB = 2;
   // Host control register in bank F
   localparam int HCTL_REQ = 0;
   localparam int HCTL_D2H = 1;
   localparam logic [1:0] HOST_CLR_DELAY = 2'h3;
   // Sample timer divisions at the core clock
   localparam int CLK_HZ = 50_000_000;
   localparam int RATE_64K_HZ = 64_000;
   localparam int RATE_16K_HZ = 16_000;
   localparam int RATE_10K_HZ = 10_000;
   localparam int RATE_4K_HZ = 4_000;
   localparam int DIV_W = 14;
   localparam logic [DIV_W-1:0] DIV_64K = DIV_W'(CLK_HZ / RATE_64K_HZ);
   localparam logic [DIV_W-1:0] DIV_16K = DIV_W'(CLK_HZ / RATE_16K_HZ);
   localparam int DIV_10K = CLK_HZ / RATE_10K_HZ;
   localparam int DIV_4K = CLK_HZ / RATE_4K_HZ;
   // Interrupt sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_REQ = 3'b010,
      ST_SERV = 3'b100
   } dhm_state_t;
endpackage

// ### src/dhm_rate_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dhm_rate_timer import dhm_pkg::*; (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic en,
   input wire logic [DIV_W-1:0] limit,
   output logic tick
);
   logic [DIV_W-1:0] cnt_reg; // Sample count, held at zero while en is low

   // Count up to the limit, one-cycle tick at the end
   always_ff @(posedge core_clk) begin
      if (!rstn || !en) begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end else if (cnt_reg >= limit - DIV_W'(1)) begin
         cnt_reg <= '0;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + DIV_W'(1);
         tick <= 1'b0;
      end
   end
endmodule // dhm_rate_timer
`default_nettype wire

// ### src/dhm_top.sv
`timescale 1ns/1ps
`default_nettype none
module dhm_top import dhm_pkg::*; #(
   parameter int DIV_10K_P = DIV_10K, // 10 kHz division
   parameter int DIV_4K_P = DIV_4K // 4 kHz division
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic dsp_wr,
   input wire logic dsp_rd,
   input wire logic [2:0] dsp_idx,
   input wire logic [15:0] dsp_wdata,
   output logic [15:0] dsp_rdata,
   output logic dsp_rvalid,
   output logic [2:0] int_line,
   input wire logic int_ack,
   input wire logic int_return,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic host_bank_f,
   input wire logic [3:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic host_instr_done,
   output logic [7:0] host_rdata,
   output logic host_rvalid,
   output logic host_irq,
   input wire logic adc_done,
   input wire logic [7:0] adc_result,
   output logic adc_enable,
   output logic adc_start,
   output logic [DAC_W-1:0] dac_data,
   output logic dac_load,
   output logic general_output_pin_a,
   output logic general_output_pin_b
);
   dhm_mbx_if mbx (); // Link to the mailbox store

   logic [2:0] req_flag_reg; // Line 2,1,0 request flags
   logic [2:0] source_mask_reg; // Per-source allow bits
   logic gie_reg; // Global interrupt enable
   logic [2:0] prio_reg; // Priority order code
   logic d2h_reg; // Core to host request
   logic [1:0] d2h_cnt_reg; // Host instructions left to clear
   logic d2h_arm_reg; // Pending host clear
   logic [15:0] acw_reg; // Analog control word
   logic [7:0] adc_data_reg; // Last converter result
   logic conv_done_reg; // Conversion complete flag
   dhm_state_t state_reg; // Interrupt sequencer state
   logic [2:0] rd_idx_reg; // Core read index, first stage
   logic rd_reg; // Core read, first stage
   logic hrd_reg; // Host read, first stage
   logic hrd_f_reg; // Host read targets bank F
   logic dac_tick; // Output sample timer tick
   logic adc_tick; // Input sample timer tick
   logic [DIV_W-1:0] dac_limit;
   logic [DIV_W-1:0] adc_limit;
   logic icw_wr, cdw_wr, acw_wr, cdw_rd, hctl_wr;
   logic [2:0] clr_strobe;
   logic [2:0] pending;
   logic [2:0] winner;
   logic [15:0] icw_view;

   // Pick one pending source in configured order
   function automatic logic [2:0] prio_pick(input logic [2:0] code,
                                           input logic [2:0] pend);
      logic [1:0] order [0:2];
      logic [2:0] pick;
      pick = 3'h0;
      case (code)
         3'b001: order = '{2'd0, 2'd2, 2'd1};
         3'b010: order = '{2'd1, 2'd0, 2'd2};
         3'b011: order = '{2'd1, 2'd2, 2'd0};
         3'b100: order = '{2'd2, 2'd0, 2'd1};
         3'b101: order = '{2'd2, 2'd1, 2'd0};
         default: order = '{2'd0, 2'd1, 2'd2};
      endcase
      // First pending source in order wins
      for (int i = 2; i >= 0; i--) begin
         if (pend[order[i]]) begin
            pick = 3'h0;
            pick[order[i]] = 1'b1;
         end
      end
      return pick;
   endfunction

   // Access decodes
   assign icw_wr = dsp_wr && (dsp_idx == IDX_ICW);
   assign cdw_wr = dsp_wr && (dsp_idx == IDX_CDW);
   assign acw_wr = dsp_wr && (dsp_idx == IDX_ACW);
   assign cdw_rd = dsp_rd && (dsp_idx == IDX_CDW);
   assign hctl_wr = host_wr && host_bank_f;
   // Clear bits act only in the write cycle
   assign clr_strobe = icw_wr ? dsp_wdata[ICW_CLR_HI:ICW_CLR_LO]
                              : 3'h0;

   // Mailbox store hookup
   assign mbx.host_we = host_wr && !host_bank_f
                        && !host_addr[3];
   assign mbx.host_waddr = host_addr[2:0];
   assign mbx.host_wdata = host_wdata;
   assign mbx.host_raddr = host_addr;
   assign mbx.dsp_we = dsp_wr && (dsp_idx <= IDX_MBX3);
   assign mbx.dsp_idx = dsp_idx[1:0];
   assign mbx.dsp_wdata = dsp_wdata;

   dhm_mailbox_mem u_mem (
      .core_clk(core_clk),
      .mbx(mbx)
   );

   // Output sample rate select
   always_comb begin
      case (acw_reg[ACW_DRATE_HI:ACW_DRATE_LO])
         2'b00: dac_limit = DIV_64K;
         2'b01: dac_limit = DIV_16K;
         2'b10: dac_limit = DIV_W'(DIV_10K_P);
         default: dac_limit = DIV_W'(DIV_4K_P);
      endcase
   end

   // Input sample rate select
   always_comb begin
      case (acw_reg[ACW_ARATE_HI:ACW_ARATE_LO])
         2'b00: adc_limit = DIV_64K;
         2'b01: adc_limit = DIV_16K;
         2'b10: adc_limit = DIV_W'(DIV_10K_P);
         default: adc_limit = DIV_W'(DIV_4K_P);
      endcase
   end

   // Output update timer, always running
   dhm_rate_timer u_dac_timer (
      .core_clk(core_clk),
      .rstn(rstn),
      .en(1'b1),
      .limit(dac_limit),
      .tick(dac_tick)
   );

   // Input sample timer, runs while converter enabled
   dhm_rate_timer u_adc_timer (
      .core_clk(core_clk),
      .rstn(rstn),
      .en(acw_reg[ACW_ADC_EN]),
      .limit(adc_limit),
      .tick(adc_tick)
   );

   // Request flags; a set in the clear cycle wins
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         req_flag_reg <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (clr_strobe[i]) begin
               req_flag_reg[i] <= 1'b0;
            end
         end
         if (hctl_wr && host_wdata[HCTL_REQ]) begin
            req_flag_reg[2] <= 1'b1;
         end
         if (adc_done) begin
            req_flag_reg[1] <= 1'b1;
         end
         if (dac_tick) begin
            req_flag_reg[0] <= 1'b1;
         end
      end
   end

   // Core-only interrupt settings
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         source_mask_reg <= 3'h0;
         gie_reg <= 1'b0;
         prio_reg <= 3'h0;
      end else if (icw_wr) begin
         source_mask_reg <= dsp_wdata[ICW_MASK_HI:ICW_MASK_LO];
         gie_reg <= dsp_wdata[ICW_GIE];
         prio_reg <= dsp_wdata[ICW_PRIO_HI:ICW_PRIO_LO];
      end
   end

   // Core to host request with delayed host clear
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         d2h_reg <= 1'b0;
         d2h_arm_reg <= 1'b0;
         d2h_cnt_reg <= 2'h0;
      end else begin
         if (hctl_wr && !host_wdata[HCTL_D2H]) begin
            // Host wrote 0: start the countdown
            d2h_arm_reg <= 1'b1;
            d2h_cnt_reg <= HOST_CLR_DELAY;
         end else if (d2h_arm_reg && host_instr_done) begin
            if (d2h_cnt_reg == 2'h1) begin
               d2h_arm_reg <= 1'b0;
            end
            d2h_cnt_reg <= d2h_cnt_reg - 2'h1;
         end
         if (icw_wr && dsp_wdata[ICW_D2H]) begin
            d2h_reg <= 1'b1;
         end else if (d2h_arm_reg && host_instr_done
                      && d2h_cnt_reg == 2'h1) begin
            d2h_reg <= 1'b0;
         end
      end
   end

   // Host sees the request bit from a flop
   assign host_irq = d2h_reg;

   // Eligible sources
   assign pending = req_flag_reg & source_mask_reg
                    & {3{gie_reg}};
   assign winner = prio_pick(prio_reg, pending);

   // Interrupt sequencer, no nesting
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         int_line <= 3'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (|pending) begin
                  int_line <= winner;
                  state_reg <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (int_ack) begin
                  int_line <= 3'h0;
                  state_reg <= ST_SERV;
               end else if (!(|pending)) begin
                  // Source withdrawn before acceptance
                  int_line <= 3'h0;
                  state_reg <= ST_IDLE;
               end
            end
            ST_SERV: begin
               if (int_return) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               int_line <= 3'h0;
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Analog control word; done bit is read-only
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         acw_reg <= ACW_RST;
      end else if (acw_wr) begin
         acw_reg <= dsp_wdata & ACW_WMASK;
      end
   end

   // Control outputs straight from the control word
   assign general_output_pin_a = acw_reg[ACW_PIN_A];
   assign general_output_pin_b = acw_reg[ACW_PIN_B];
   assign adc_enable = acw_reg[ACW_ADC_EN];

   // Conversion launch: on demand, or on timer expiry while the start bit is clear
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         adc_start <= 1'b0;
      end else begin
         adc_start <= (acw_wr && dsp_wdata[ACW_START]
                       && dsp_wdata[ACW_ADC_EN])
                      || (adc_tick && !acw_reg[ACW_START]
                          && acw_reg[ACW_ADC_EN]);
      end
   end

   // Result capture and done flag; set beats read clear
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         adc_data_reg <= 8'h00;
         conv_done_reg <= 1'b0;
      end else if (adc_done) begin
         adc_data_reg <= adc_result;
         conv_done_reg <= 1'b1;
      end else if (cdw_rd) begin
         conv_done_reg <= 1'b0;
      end
   end

   // Output sample load
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         dac_data <= '0;
         dac_load <= 1'b0;
      end else begin
         dac_load <= cdw_wr;
         if (cdw_wr) begin
            dac_data <= dsp_wdata[DAC_W-1:0];
         end
      end
   end

   // Interrupt word as the core reads it
   always_comb begin
      icw_view = 16'h0000;
      icw_view[ICW_REQ_HI:ICW_REQ_LO] = req_flag_reg;
      icw_view[ICW_MASK_HI:ICW_MASK_LO] = source_mask_reg;
      icw_view[ICW_D2H] = d2h_reg;
      icw_view[ICW_GIE] = gie_reg;
      icw_view[ICW_PRIO_HI:ICW_PRIO_LO] = prio_reg;
   end

   // Read pipeline first stage
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rd_reg <= 1'b0;
         rd_idx_reg <= 3'h0;
         hrd_reg <= 1'b0;
         hrd_f_reg <= 1'b0;
      end else begin
         rd_reg <= dsp_rd;
         rd_idx_reg <= dsp_idx;
         hrd_reg <= host_rd;
         hrd_f_reg <= host_bank_f;
      end
   end

   // Core read data, second stage
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         dsp_rdata <= 16'h0000;
         dsp_rvalid <= 1'b0;
      end else begin
         dsp_rvalid <= rd_reg;
         if (rd_reg) begin
            case (rd_idx_reg)
               IDX_ICW: dsp_rdata <= icw_view;
               IDX_CDW: dsp_rdata <= {6'h00, adc_data_reg,
                                      2'b00};
               IDX_ACW: begin
                  dsp_rdata <= acw_reg;
                  dsp_rdata[ACW_DONE] <= conv_done_reg;
               end
               default: begin
                  if (rd_idx_reg <= IDX_MBX3) begin
                     dsp_rdata <= mbx.dsp_rdata;
                  end else begin
                     dsp_rdata <= 16'h0000;
                  end
               end
            endcase
         end
      end
   end

   // Host read data: bank B bytes or bank F control
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         host_rdata <= 8'h00;
         host_rvalid <= 1'b0;
      end else begin
         host_rvalid <= hrd_reg;
         if (hrd_reg && hrd_f_reg) begin
            host_rdata <= {6'h00, d2h_reg, req_flag_reg[2]};
         end else if (hrd_reg) begin
            host_rdata <= mbx.host_rdata;
         end
      end
   end
endmodule // dhm_top
`default_nettype wire

// ### tb/dhm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dhm_host_model (
   input wire logic core_clk,
   output logic host_wr,
   output logic host_rd,
   output logic host_bank_f,
   output logic [3:0] host_addr,
   output logic [7:0] host_wdata,
   output logic host_instr_done,
   input wire logic [7:0] host_rdata,
   input wire logic host_rvalid
);
   // Idle host bus at time zero
   initial begin
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_bank_f = 1'b0;
      host_addr = 4'h0;
      host_wdata = 8'h00;
      host_instr_done = 1'b0;
   end
   // One byte write; lines scrambled once released
   task automatic hw(input logic f, input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      host_wr = 1'b1;
      host_bank_f = f;
      host_addr = a;
      host_wdata = d;
      @(posedge core_clk);
      #1;
      host_wr = 1'b0;
      host_addr = ~a;
      host_wdata = ~d;
   endtask
   // One byte read, bounded wait for the answer
   task automatic hr(input logic f, input logic [3:0] a, output logic [7:0] d);
      int n;
      @(posedge core_clk);
      #1;
      host_rd = 1'b1;
      host_bank_f = f;
      host_addr = a;
      @(posedge core_clk);
      #1;
      host_rd = 1'b0;
      host_addr = ~a;
      for (n = 0; n < 8 && host_rvalid !== 1'b1; n++) @(negedge core_clk);
      d = host_rdata;
      if (n == 8) begin
         tb_top.num_errors++;
         tb_top.results();
      end
   endtask
   // Completed host instructions, one pulse each
   task automatic step(input int cnt);
      repeat (cnt) begin
         @(posedge core_clk);
         #1;
         host_instr_done = 1'b1;
         @(posedge core_clk);
         #1;
         host_instr_done = 1'b0;
      end
   endtask
endmodule // dhm_host_model
`default_nettype wire

// ### tb/dhm_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dhm_top_monitor import dhm_pkg::*; (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic dsp_wr,
   input wire logic dsp_rd,
   input wire logic [2:0] dsp_idx,
   input wire logic [15:0] dsp_wdata,
   input wire logic dsp_rvalid,
   input wire logic [2:0] int_line,
   input wire logic int_ack,
   input wire logic int_return,
   input wire logic host_rd,
   input wire logic host_rvalid,
   input wire logic host_irq,
   input wire logic adc_start,
   input wire logic [DAC_W-1:0] dac_data,
   input wire logic dac_load,
   input wire logic general_output_pin_a,
   input wire logic general_output_pin_b
);
   // One clock, one reset for every check
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   logic serv_reg; // Core inside a service routine
   logic wr_cdw; // Core writes the data word
   logic wr_acw; // Core writes the analog word
   assign wr_cdw = dsp_wr && (dsp_idx == IDX_CDW);
   assign wr_acw = dsp_wr && (dsp_idx == IDX_ACW);
   // Service lasts from acceptance to return
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         serv_reg <= 1'b0;
      end else if (int_return) begin
         serv_reg <= 1'b0;
      end else if (int_ack && int_line != 3'h0) begin
         serv_reg <= 1'b1;
      end
   end
   chk_core_read_lat: assert property (dsp_rd |-> ##2 dsp_rvalid)
      else $error("core read answer not two cycles later");
   chk_host_read_lat: assert property (host_rd |-> ##2 host_rvalid)
      else $error("host read answer not two cycles later");
   chk_line_onehot: assert property ($onehot0(int_line))
      else $error("more than one request line raised");
   chk_ack_drops: assert property (int_ack && int_line != 3'h0 |=>
      int_line == 3'h0)
      else $error("request line kept after acceptance");
   chk_no_nesting: assert property (serv_reg |-> int_line == 3'h0)
      else $error("request raised during service");
   chk_dac_sample: assert property (wr_cdw |=> dac_load &&
      dac_data == $past(dsp_wdata[DAC_W-1:0]))
      else $error("output sample not loaded from write");
   chk_dac_quiet: assert property (!wr_cdw |=> !dac_load)
      else $error("output load without data write");
   chk_pin_follow: assert property (wr_acw |=>
      {general_output_pin_b, general_output_pin_a} == $past(dsp_wdata[7:6]))
      else $error("output pins differ from written bits");
   chk_start_launch: assert property (wr_acw &&
      dsp_wdata[ACW_START] && dsp_wdata[ACW_ADC_EN] |=> adc_start)
      else $error("start write gave no conversion launch");
   chk_d2h_set: assert property (dsp_wr && dsp_idx == IDX_ICW &&
      dsp_wdata[ICW_D2H] |=> host_irq [*2])
      else $error("core-to-host request not set");
endmodule // dhm_top_monitor
bind dhm_top dhm_top_monitor mon (.core_clk(core_clk), .rstn(rstn),
   .dsp_wr(dsp_wr), .dsp_rd(dsp_rd), .dsp_idx(dsp_idx),
   .dsp_wdata(dsp_wdata), .dsp_rvalid(dsp_rvalid), .int_line(int_line),
   .int_ack(int_ack), .int_return(int_return), .host_rd(host_rd),
   .host_rvalid(host_rvalid), .host_irq(host_irq), .adc_start(adc_start),
   .dac_data(dac_data), .dac_load(dac_load),
   .general_output_pin_a(general_output_pin_a),
   .general_output_pin_b(general_output_pin_b));
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
num_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top import dhm_pkg::*;;
   logic core_clk, rstn, dsp_wr, dsp_rd, dsp_rvalid, int_ack, int_return;
   logic [2:0] dsp_idx, int_line;
   logic [15:0] dsp_wdata, dsp_rdata, rd;
   logic host_wr, host_rd, host_bank_f, host_instr_done, host_rvalid;
   logic host_irq, adc_done, adc_enable, adc_start, dac_load, pin_a, pin_b;
   logic [3:0] host_addr;
   logic [7:0] host_wdata, host_rdata, adc_result, hb;
   logic [DAC_W-1:0] dac_data;
   logic [2:0] win [8]; // Expected winner per priority code
   int num_errors, comparisons, i, n;
   // Block under test with short sample divisions
   dhm_top #(.DIV_10K_P(20), .DIV_4K_P(40)) uut (.core_clk(core_clk),
      .rstn(rstn), .dsp_wr(dsp_wr), .dsp_rd(dsp_rd), .dsp_idx(dsp_idx),
      .dsp_wdata(dsp_wdata), .dsp_rdata(dsp_rdata), .dsp_rvalid(dsp_rvalid),
      .int_line(int_line), .int_ack(int_ack), .int_return(int_return),
      .host_wr(host_wr), .host_rd(host_rd), .host_bank_f(host_bank_f),
      .host_addr(host_addr), .host_wdata(host_wdata),
      .host_instr_done(host_instr_done), .host_rdata(host_rdata),
      .host_rvalid(host_rvalid), .host_irq(host_irq), .adc_done(adc_done),
      .adc_result(adc_result), .adc_enable(adc_enable),
      .adc_start(adc_start), .dac_data(dac_data), .dac_load(dac_load),
      .general_output_pin_a(pin_a), .general_output_pin_b(pin_b));
   // Host controller on the far side
   dhm_host_model host (.core_clk(core_clk), .host_wr(host_wr),
      .host_rd(host_rd), .host_bank_f(host_bank_f), .host_addr(host_addr),
      .host_wdata(host_wdata), .host_instr_done(host_instr_done),
      .host_rdata(host_rdata), .host_rvalid(host_rvalid));
   // 50 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Core register write
   task automatic dw(input logic [2:0] x, input logic [15:0] d);
      @(posedge core_clk);
      #1;
      dsp_wr = 1'b1;
      dsp_idx = x;
      dsp_wdata = d;
      @(posedge core_clk);
      #1;
      dsp_wr = 1'b0;
      dsp_wdata = ~d;
   endtask
   // Core register read, bounded wait
   task automatic dr(input logic [2:0] x, output logic [15:0] d);
      @(posedge core_clk);
      #1;
      dsp_rd = 1'b1;
      dsp_idx = x;
      @(posedge core_clk);
      #1;
      dsp_rd = 1'b0;
      for (n = 0; n < 8 && dsp_rvalid !== 1'b1; n++) @(negedge core_clk);
      d = dsp_rdata;
      if (n == 8) begin
         num_errors++;
         results();
      end
   endtask
   // One pulse on a core-side strobe
   task automatic pulse(input int w, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      if (w == 0) int_ack = 1'b1;
      else if (w == 1) int_return = 1'b1;
      else begin
         adc_done = 1'b1;
         adc_result = d;
      end
      @(posedge core_clk);
      #1;
      int_ack = 1'b0;
      int_return = 1'b0;
      adc_done = 1'b0;
      adc_result = ~d;
   endtask
   // Counts, verdict and end of run
   task automatic results;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      {rstn, dsp_wr, dsp_rd, int_ack, int_return, adc_done} = 6'h00;
      dsp_idx = 3'h0;
      dsp_wdata = 16'h0000;
      adc_result = 8'h00;
      num_errors = 0;
      comparisons = 0;
      win = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h1, 3'h1};
      repeat (20) @(posedge core_clk);
      #1;
      rstn = 1'b1;
      dr(IDX_ACW, rd);
      `CHK("analog word", 16'h0008, rd)
      dr(IDX_ICW, rd);
      `CHK("interrupt word", 16'h0000, rd)
      $display("test reset done");
      // Host bytes in, core words out, one read-only host write
      for (i = 0; i < 8; i++) host.hw(1'b0, 4'(i), 8'(8'h10 + i));
      host.hw(1'b0, 4'h8, 8'hEE);
      for (i = 0; i < 4; i++) dw(3'(i), {8'(8'hC0 + i), 8'(8'h30 + i)});
      for (i = 0; i < 4; i++) begin
         dr(3'(i), rd);
         `CHK("mbx word", {8'(8'h10 + 2*i), 8'(8'h11 + 2*i)}, rd)
         host.hr(1'b0, 4'(8 + 2 * i), hb);
         `CHK("mbx hi", 8'(8'hC0 + i), hb)
         host.hr(1'b0, 4'(9 + 2 * i), hb);
         `CHK("mbx lo", 8'(8'h30 + i), hb)
      end
      host.hr(1'b0, 4'h0, hb);
      `CHK("host byte", 8'h10, hb)
      $display("test mailbox done");
      // All three sources pending with interrupts off
      dw(IDX_ACW, 16'h8000);
      host.hw(1'b1, 4'h0, 8'h01);
      pulse(2, 8'h5A);
      repeat (25) @(posedge core_clk);
      dr(IDX_ICW, rd);
      `CHK("flags", 3'h7, rd[15:13])
      dw(IDX_ICW, 16'h1C00);
      repeat (4) @(negedge core_clk);
      `CHK("gated", 3'h0, int_line)
      dw(IDX_ICW, 16'h0100);
      repeat (4) @(negedge core_clk);
      `CHK("masked", 3'h0, int_line)
      for (i = 0; i < 8; i++) begin
         dw(IDX_ICW, {6'h07, 2'b01, 3'(i), 5'h00});
         for (n = 0; n < 60 && int_line === 3'h0; n++) @(negedge core_clk);
         `CHK("winner", win[i], int_line)
         if (n == 60) results();
         pulse(0, 8'h00);
         repeat (3) @(negedge core_clk);
         `CHK("nested", 3'h0, int_line)
         pulse(1, 8'h00);
         dw(IDX_ICW, 16'h0000);
      end
      dw(IDX_ICW, 16'h0018);
      dr(IDX_ICW, rd);
      `CHK("cleared", 5'h00, {rd[15:14], rd[4:2]})
      $display("test interrupts done");
      // Core-to-host request and its delayed host clear
      dw(IDX_ICW, 16'h0200);
      `CHK("d2h set", 1'b1, host_irq)
      host.hr(1'b1, 4'h0, hb);
      `CHK("bank f", 8'h02, hb)
      host.hw(1'b1, 4'h0, 8'h00);
      host.step(2);
      `CHK("d2h held", 1'b1, host_irq)
      host.step(1);
      repeat (2) @(negedge core_clk);
      `CHK("d2h clear", 1'b0, host_irq)
      $display("test host request done");
      // Converter paths and output pins
      dw(IDX_CDW, 16'hFFFF);
      @(negedge core_clk);
      `CHK("dac", 10'h3FF, dac_data)
      dw(IDX_ACW, 16'h80A8);
      `CHK("start", 1'b1, adc_start)
      `CHK("pins b", 2'b10, {pin_b, pin_a})
      dw(IDX_ACW, 16'h8062);
      `CHK("pins a", 3'b011, {pin_b, pin_a, adc_enable})
      for (n = 0; n < 60 && adc_start !== 1'b1; n++) @(negedge core_clk);
      `CHK("timer start", 1'b1, adc_start)
      if (n == 60) results();
      dr(IDX_CDW, rd);
      `CHK("adc old", 16'h0168, rd)
      pulse(2, 8'hA5);
      dr(IDX_ACW, rd);
      `CHK("done set", 1'b1, rd[ACW_DONE])
      `CHK("analog rb", 16'h8062, rd & ACW_WMASK)
      dr(IDX_CDW, rd);
      `CHK("adc data", 16'h0294, rd)
      dr(IDX_ACW, rd);
      `CHK("done clear", 1'b0, rd[ACW_DONE])
      $display("test converter done");
      results();
   end
endmodule // tb_top
`default_nettype wire
